// ==== rtl/liu_defs.svh ====
// constants of the line status block
`ifndef LIU_DEFS_SVH
`define LIU_DEFS_SVH
`define LIU_CLK_HZ 125000000
`define LIU_PERSIST_S 5
`define LIU_AIS_RUN 512
`define LIU_AIS_RUN_MAX 65535
`define LIU_WIN_W 5
`define LIU_UP_MASK 5'h1f
`define LIU_DOWN_MASK 5'h07
`define LIU_ADR_CTRL 4'h0
`define LIU_ADR_IRQ_EN 4'h4
`define LIU_ADR_STATUS 4'h8
`define LIU_ADR_IRQ_ST 4'hc
`define LIU_CTRL_MODE_LO 0
`define LIU_CTRL_MODE_HI 1
`define LIU_CTRL_SINGLE 2
`define LIU_ST_LOOP 3
`define LIU_ST_AIS 2
`define LIU_ST_LOS 1
`define LIU_ST_QRSS 0
`define LIU_CTRL_RESET 3'h0
`define LIU_EVT_RESET 4'h0
`define LIU_MODE_UP 2'h1
`define LIU_MODE_DOWN 2'h2
`define LIU_MODE_AUTO 2'h3
`endif

// ==== rtl/liu_pkg.sv ====
// types of the line status block
`default_nettype none
package liu_pkg;
	typedef enum logic [2:0] {
		LOOP_OFF = 3'h1,
		LOOP_SEARCH_UP = 3'h2,
		LOOP_ACTIVE = 3'h4
	} loop_state_t;
	typedef logic [1:0] loop_mode_t;
endpackage
`default_nettype wire

// ==== rtl/loop_detect_if.sv ====
// link between status logic and loop-code detector
`timescale 1ns/100ps
`default_nettype none
interface loop_detect_if;
	logic sel_down;
	logic restart;
	logic held;
	modport ctrl (output sel_down, output restart, input held);
	modport det (input sel_down, input restart, output held);
endinterface
`default_nettype wire

// ==== rtl/bit_sync.sv ====
// two-flop synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;
	generate
		if (WIDTH < 1) begin : g_chk
			$error("bit_sync needs WIDTH of at least 1");
		end
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					meta[i] <= 1'b0;
					sync_o[i] <= 1'b0;
				end else begin
					meta[i] <= async_i[i];
					sync_o[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule // bit_sync
`default_nettype wire

// ==== rtl/loop_code_detector.sv ====
// repeating loop-code detector with persistence timer
`timescale 1ns/100ps
`default_nettype none
`include "liu_defs.svh"
module loop_code_detector #(
	parameter longint PERSIST_CYC = 64'(`LIU_PERSIST_S) * 64'(`LIU_CLK_HZ)
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// received line bits
	input wire logic bit_en_i,
	input wire logic bit_i,
	// control side
	loop_detect_if.det lc
);
	logic [`LIU_WIN_W-1:0] win;
	logic [`LIU_WIN_W-1:0] masked;
	logic match;
	logic [63:0] cnt;
	generate
		if (PERSIST_CYC < 1) begin : g_chk
			$error("PERSIST_CYC must be at least 1");
		end
	endgenerate
	// one 1 per period in the window: any rotation of 00001 or 001
	assign masked = win & (lc.sel_down ? `LIU_DOWN_MASK : `LIU_UP_MASK);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win <= '0;
		end else if (bit_en_i) begin
			win <= {win[`LIU_WIN_W-2:0], bit_i};
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || lc.restart) begin
			match <= 1'b0;
		end else if (bit_en_i) begin
			match <= (masked != '0) && ((masked & (masked - 1'b1)) == '0);
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || lc.restart || !match) begin
			cnt <= '0;
		end else if (cnt <= PERSIST_CYC) begin
			cnt <= cnt + 64'h1;
		end
	end
	assign lc.held = cnt > PERSIST_CYC;
endmodule // loop_code_detector
`default_nettype wire

// ==== rtl/liu_loop_code_alarm_status.sv ====
// line receive status: loop codes, alarms, interrupts, wishbone registers
// How it works
// - manual loop-up: set loop status after 00001 repeats over five seconds
// - manual loop-up: status stays while pattern arrives, clears when it stops
// - manual loop-down: set loop status after 001 repeats over five seconds
// - manual loop-down: status stays while pattern arrives, clears when it stops
// - in single-rail mode, loop status changes raise an interrupt in every loop mode when enabled
// - entering automatic mode clears loop status and searches for loop-up
// - automatic: loop-up over five seconds sets status and remote loop-back together
// - automatic: status stays high while remote loop-back is active
// - automatic: loop-down over five seconds releases loop-back, clears status
// - all-ones status bit follows received all-ones, interrupts when enabled
// - loss-of-signal status bit follows receiver, interrupts when enable bit 1 set
// - test pattern lock bit follows receiver, interrupts when enable bit 0 set
// - status and interrupt registers only work in single-rail mode
// - all-ones interrupt enable is bit 2 of the enable register
// - latched interrupt bits set on each change, cleared by reading them
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "liu_defs.svh"
module liu_loop_code_alarm_status
	import liu_pkg::*;
#(
	parameter longint PERSIST_CYC = 64'(`LIU_PERSIST_S) * 64'(`LIU_CLK_HZ),
	parameter int AIS_RUN = `LIU_AIS_RUN
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// receive line pins
	input wire logic rx_bit_clk_i,
	input wire logic rx_data_i,
	input wire logic rx_los_i,
	input wire logic rx_qrss_lock_i,
	// outputs
	output logic remote_loop_o,
	output logic irq_o
);
	generate
		if (AIS_RUN < 1 || AIS_RUN > `LIU_AIS_RUN_MAX) begin : g_chk
			$error("AIS_RUN out of range");
		end
		// the persistence counter cannot time a zero span
		if (PERSIST_CYC < 1) begin : g_chk_persist
			$error("PERSIST_CYC must be at least 1");
		end
	endgenerate

	// pin synchronisers
	// pin levels reach the status register three clocks late
	logic [3:0] pins_s;
	bit_sync #(.WIDTH(4)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({rx_bit_clk_i, rx_data_i, rx_los_i, rx_qrss_lock_i}),
		.sync_o(pins_s)
	);
	logic bclk_s;
	logic data_s;
	logic los_s;
	logic qrss_s;
	assign bclk_s = pins_s[3];
	assign data_s = pins_s[2];
	assign los_s = pins_s[1];
	assign qrss_s = pins_s[0];

	// rising edge of the line clock marks one received bit
	// line clock high and low must each span two clocks
	logic bclk_d;
	logic bit_en;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bclk_d <= 1'b0;
		end else begin
			bclk_d <= bclk_s;
		end
	end
	assign bit_en = bclk_s & ~bclk_d;

	// control registers
	logic [2:0] ctrl;
	logic [3:0] irq_en;
	loop_mode_t mode;
	logic single_rail;
	assign mode = {ctrl[`LIU_CTRL_MODE_HI], ctrl[`LIU_CTRL_MODE_LO]};
	assign single_rail = ctrl[`LIU_CTRL_SINGLE];

	// bus access
	logic wb_req;
	logic wr_take;
	logic rd_take;
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_take = wb_req & wb_we_i & wb_sel_i[0];
	assign rd_take = wb_req & ~wb_we_i;
	// a held strobe is masked by ack, so one request acts once
	logic hit_ctrl;
	logic hit_irq_en;
	logic hit_irq_st;
	assign hit_ctrl = wb_adr_i == `LIU_ADR_CTRL;
	assign hit_irq_en = wb_adr_i == `LIU_ADR_IRQ_EN;
	assign hit_irq_st = wb_adr_i == `LIU_ADR_IRQ_ST;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `LIU_CTRL_RESET;
		end else if (wr_take && hit_ctrl) begin
			ctrl <= wb_dat_i[2:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en <= `LIU_EVT_RESET;
		end else if (wr_take && hit_irq_en) begin
			irq_en <= wb_dat_i[3:0];
		end
	end

	// loop-code detector
	loop_detect_if lc ();
	loop_code_detector #(.PERSIST_CYC(PERSIST_CYC)) u_det (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bit_en_i(bit_en),
		.bit_i(data_s),
		.lc(lc)
	);

	// automatic loop-back sequencing
	// leaving automatic mode drops loop-back at once
	loop_state_t state;
	loop_state_t next_state;
	loop_mode_t mode_d;
	logic loop_stat;
	logic next_loop_stat;

	always_comb begin
		next_state = state;
		unique case (state)
			LOOP_OFF: begin
				if (mode == `LIU_MODE_AUTO) begin
					next_state = LOOP_SEARCH_UP;
				end
			end
			LOOP_SEARCH_UP: begin
				if (mode != `LIU_MODE_AUTO) begin
					next_state = LOOP_OFF;
				end else if (lc.held) begin
					next_state = LOOP_ACTIVE;
				end
			end
			LOOP_ACTIVE: begin
				if (mode != `LIU_MODE_AUTO) begin
					next_state = LOOP_OFF;
				end else if (lc.held) begin
					next_state = LOOP_SEARCH_UP;
				end
			end
		endcase
	end

	always_comb begin
		unique case (next_state)
			LOOP_OFF: begin
				// manual modes follow the persistence timer directly
				next_loop_stat = (mode == `LIU_MODE_UP || mode == `LIU_MODE_DOWN) && lc.held;
			end
			LOOP_SEARCH_UP: begin
				next_loop_stat = 1'b0;
			end
			LOOP_ACTIVE: begin
				next_loop_stat = 1'b1;
			end
		endcase
	end

	// searching pattern: down in manual-down mode or while looped
	assign lc.sel_down = (state == LOOP_OFF) ? (mode == `LIU_MODE_DOWN) : (state == LOOP_ACTIVE);
	// restart timer on any mode or search change
	assign lc.restart = (next_state != state) || (mode != mode_d);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= LOOP_OFF;
			mode_d <= 2'h0;
		end else begin
			state <= next_state;
			mode_d <= mode;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loop_stat <= 1'b0;
			remote_loop_o <= 1'b0;
		end else begin
			loop_stat <= next_loop_stat;
			remote_loop_o <= (next_state == LOOP_ACTIVE);
		end
	end

	// all-ones run detection on the received stream
	// run counter saturates so it cannot wrap back to zero
	logic [15:0] ones_run;
	logic ais;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ones_run <= 16'h0;
		end else if (bit_en) begin
			if (!data_s) begin
				ones_run <= 16'h0;
			end else if (ones_run < 16'(AIS_RUN)) begin
				ones_run <= ones_run + 16'h1;
			end
		end
	end
	assign ais = ones_run >= 16'(AIS_RUN);

	// status register, live only in single-rail mode
	// leaving single-rail zeroes status without latching a change
	logic [3:0] status;
	logic [3:0] next_status;
	always_comb begin
		next_status = `LIU_EVT_RESET;
		if (single_rail) begin
			next_status[`LIU_ST_LOOP] = loop_stat;
			next_status[`LIU_ST_AIS] = ais;
			next_status[`LIU_ST_LOS] = los_s;
			next_status[`LIU_ST_QRSS] = qrss_s;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= `LIU_EVT_RESET;
		end else begin
			status <= next_status;
		end
	end

	// latched change bits, read clears, a new change wins
	logic [3:0] irq_st;
	logic [3:0] chg;
	logic irq_clr;
	assign chg = (status ^ next_status) & {4{single_rail}};
	assign irq_clr = rd_take && hit_irq_st;
	generate
		for (genvar i = 0; i < $bits(irq_st); i++) begin : g_irq
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					irq_st[i] <= 1'b0;
				end else if (chg[i]) begin
					irq_st[i] <= 1'b1;
				end else if (irq_clr) begin
					irq_st[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_st & irq_en);
		end
	end

	// read mux and acknowledge
	// unmapped words read zero, writes to them vanish
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0;
		unique case (wb_adr_i)
			`LIU_ADR_CTRL: rd_data = {29'h0, ctrl};
			`LIU_ADR_IRQ_EN: rd_data = {28'h0, irq_en};
			`LIU_ADR_STATUS: rd_data = {28'h0, status};
			`LIU_ADR_IRQ_ST: rd_data = {28'h0, irq_st};
			default: rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= rd_take ? rd_data : 32'h0;
		end
	end
endmodule // liu_loop_code_alarm_status
`default_nettype wire

// ==== test/liu_checker.sv ====
// assertions on the line status block ports
`timescale 1ns/100ps
`default_nettype none
`include "liu_defs.svh"
module liu_checker #(
	parameter longint PERSIST_CYC = 200
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus and outputs
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic remote_loop_o,
	input wire logic irq_o
);
	logic [63:0] since_wr;
	// cycles since last control write, a mode change restarts the timer
	always_ff @(posedge clk_i) begin
		if (rst_i || (wb_ack_o && wb_we_i && wb_adr_i == `LIU_ADR_CTRL)) begin
			since_wr <= 64'h0;
		end else if (since_wr != 64'hffffffffffffffff) begin
			since_wr <= since_wr + 64'h1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack without request");
	chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chk_dat_byte: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_loop_persist: assert property ($rose(remote_loop_o) |-> since_wr > PERSIST_CYC)
		else $error("loop-back too early");
	chk_loop_hold: assert property ($rose(remote_loop_o) |=> remote_loop_o [*8])
		else $error("loop-back dropped");
	chk_irq_drop: assert property ($fell(irq_o) |->
		$past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
		else $error("irq fell without access");
	cov_loop: cover property ($rose(remote_loop_o));
	cov_irq: cover property ($rose(irq_o));
	cov_wr: cover property (wb_ack_o && wb_we_i);
endmodule // liu_checker
`default_nettype wire

// ==== test/line_model.sv ====
// far-end line: bit clock and repeating code patterns
`timescale 1ns/100ps
`default_nettype none
module line_model (
	// clock and pattern select
	input wire logic clk_i,
	input wire logic [2:0] pat_i,
	// line pins
	output logic bit_clk_o,
	output logic data_o
);
	logic [2:0] ph = 3'h0;
	logic [3:0] k = 4'h0;
	// eight clocks a bit, data moves well before the rising edge
	always @(posedge clk_i) begin
		ph <= ph + 3'h1;
		bit_clk_o <= ph[2];
		if (ph == 3'h1) begin
			k <= (k == 4'he) ? 4'h0 : k + 4'h1;
			case (pat_i)
			3'h1: data_o <= (k % 5) == 4;
			3'h2: data_o <= (k % 3) == 2;
			3'h3: data_o <= 1'b1;
			3'h4: data_o <= 1'($urandom);
			default: data_o <= 1'b0;
			endcase
		end
	end
endmodule // line_model
`default_nettype wire

// ==== test/liu_loop_code_alarm_status_test.sv ====
// bench for the line status block
`timescale 1ns/100ps
`default_nettype none
`include "liu_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t %h %h", $time, a, b); end end
module liu_loop_code_alarm_status_test;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, los = 1'b0, qrss = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'hf;
	logic [31:0] wd = 32'h0, rd, q, r;
	logic [2:0] pat = 3'h0;
	logic bclk, bdat, loop, irq, ack;
	int error_cnt = 0, n_tests = 0;
	always #4 clk_i = ~clk_i;
	liu_loop_code_alarm_status #(.PERSIST_CYC(200), .AIS_RUN(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_ack_o(ack), .rx_bit_clk_i(bclk), .rx_data_i(bdat), .rx_los_i(los),
		.rx_qrss_lock_i(qrss), .remote_loop_o(loop), .irq_o(irq));
	line_model far (.clk_i(clk_i), .pat_i(pat), .bit_clk_o(bclk), .data_o(bdat));
	function automatic logic [31:0] st(input logic l, input logic a, input logic s, input logic g);
		return (32'(l) << `LIU_ST_LOOP) | (32'(a) << `LIU_ST_AIS) | (32'(s) << `LIU_ST_LOS) | 32'(g);
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	task automatic stop_test;
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
	initial begin
		r = $urandom(32'h66e4);
		tick(2);
		rst_i <= 1'b0;
		for (int i = 0; i < 4; i++) rchk(4'(i * 4), 32'h0);
		bus(1'b1, `LIU_ADR_CTRL, 32'h7, 4'he);
		rchk(`LIU_ADR_CTRL, 32'h0);
		bus(1'b1, 4'h2, 32'hff);
		rchk(4'h2, 32'h0);
		bus(1'b1, `LIU_ADR_STATUS, 32'hff);
		rchk(`LIU_ADR_STATUS, 32'h0);
		repeat (4) begin
			r = $urandom;
			bus(1'b1, `LIU_ADR_IRQ_EN, r);
			rchk(`LIU_ADR_IRQ_EN, r & 32'hf);
		end
		bus(1'b1, `LIU_ADR_CTRL, 32'h4);
		bus(1'b1, `LIU_ADR_IRQ_EN, 32'h3);
		for (int i = 0; i < 2; i++) begin
			{los, qrss} <= 2'(2 >> i);
			tick(8);
			`CHK(irq, 1'b1)
			rchk(`LIU_ADR_STATUS, st(0, 0, i == 0, i == 1));
			rchk(`LIU_ADR_IRQ_ST, st(0, 0, i == 0, i == 1));
			rchk(`LIU_ADR_IRQ_ST, 32'h0);
			{los, qrss} <= 2'h0;
			tick(8);
			rchk(`LIU_ADR_IRQ_ST, st(0, 0, i == 0, i == 1));
		end
		bus(1'b1, `LIU_ADR_IRQ_EN, 32'h4);
		los <= 1'b1;
		tick(8);
		`CHK(irq, 1'b0)
		los <= 1'b0;
		tick(8);
		rchk(`LIU_ADR_IRQ_ST, st(0, 0, 1, 0));
		pat <= 3'h3;
		tick(200);
		`CHK(irq, 1'b1)
		rchk(`LIU_ADR_STATUS, st(0, 1, 0, 0));
		pat <= 3'h0;
		tick(40);
		rchk(`LIU_ADR_STATUS, 32'h0);
		rchk(`LIU_ADR_IRQ_ST, st(0, 1, 0, 0));
		for (int m = 1; m < 4; m++) begin
			bus(1'b1, `LIU_ADR_CTRL, 32'(4 + m));
			bus(1'b1, `LIU_ADR_IRQ_EN, 32'h8);
			rchk(`LIU_ADR_STATUS, 32'h0);
			pat <= (m == 2) ? 3'h2 : 3'h1;
			tick(150);
			pat <= 3'h0;
			tick(48);
			pat <= (m == 2) ? 3'h2 : 3'h1;
			tick(150);
			rchk(`LIU_ADR_STATUS, 32'h0);
			tick(250);
			rchk(`LIU_ADR_STATUS, st(1, 0, 0, 0));
			`CHK(loop, m == 3)
			`CHK(irq, 1'b1)
			rchk(`LIU_ADR_IRQ_ST, st(1, 0, 0, 0));
			pat <= 3'h4;
			tick(80);
			rchk(`LIU_ADR_STATUS, st(m == 3, 0, 0, 0));
			`CHK(loop, m == 3)
			if (m == 3) begin
				pat <= 3'h2;
				tick(400);
				rchk(`LIU_ADR_STATUS, 32'h0);
				`CHK(loop, 1'b0)
			end
			`CHK(irq, 1'b1)
			rchk(`LIU_ADR_IRQ_ST, st(1, 0, 0, 0));
			pat <= 3'h0;
		end
		bus(1'b1, `LIU_ADR_CTRL, 32'h0);
		los <= 1'b1;
		tick(8);
		rchk(`LIU_ADR_STATUS, 32'h0);
		stop_test();
	end
endmodule // liu_loop_code_alarm_status_test
bind liu_loop_code_alarm_status liu_checker #(.PERSIST_CYC(PERSIST_CYC)) chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.remote_loop_o(remote_loop_o), .irq_o(irq_o));
`default_nettype wire
